// >>> tb/ccu_link_props.sv
// Assertions on the link between the unit and its partner.
`timescale 1ns/1ps
`default_nettype none
module ccu_link_props (
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        SRST,
    // Link
    input wire logic [15:0] timer_count,
    input wire logic        timer_tick,
    input wire logic        timer_clear,
    input wire logic        conv_start,
    input wire logic        pin_oe
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    property p_conv_pulse; conv_start |=> !conv_start; endproperty
    a_conv_pulse: assert property (p_conv_pulse) else $error("start too long");
    property p_clear_pulse; timer_clear |=> !timer_clear; endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear too long");
    property p_clear_tick; timer_clear |-> $past(timer_tick); endproperty
    a_clear_tick: assert property (p_clear_tick) else $error("clear off tick");
    property p_clear_zero; timer_clear && timer_tick |=> timer_count == 16'h0000; endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("timer not cleared");
    property p_step; timer_tick && !timer_clear |=> timer_count == $past(timer_count) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("timer step wrong");
    property p_hold; !timer_tick |=> $stable(timer_count); endproperty
    a_hold: assert property (p_hold) else $error("timer moved");
    property p_clear_cause; conv_start |-> $past(timer_clear); endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("start without clear");
    property p_reset_idle;
        $fell(SRST) |-> !timer_clear && !conv_start && !pin_oe && timer_count == 16'h0000;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("link busy after reset");
endmodule : ccu_link_props
`default_nettype wire

// >>> tb/ccu_unit_tb.sv
// Self-checking bench for the capture/compare unit and its partner.
`timescale 1ns/1ps
`default_nettype none
module ccu_unit_tb import ccu_pkg::*;;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hF;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_r;
    logic        ack;
    logic        port_data = 1'b0;
    logic        timer_on = 1'b0;
    logic        conv_on = 1'b0;
    logic        pin_ext = 1'b0;
    wire         pin_level;
    logic        conv_busy, overflow, pin_drive, pin_drive_oe;
    logic [31:0] q;
    logic [7:0]  lo;
    logic [15:0] tcap;
    logic [15:0] maxc = 16'h0000;
    logic        mon = 1'b0;
    int          mismatches = 0, num_checks = 0, cycles = 0;
    int          nconv = 0, nbusy = 0, novf = 0;
    ccu_mode_t   cmp_mode[4] = '{CCU_CMP_SET, CCU_CMP_CLEAR, CCU_CMP_TOGGLE, CCU_CMP_FLAG};
    logic [15:0] cmp_at[4] = '{16'h0040, 16'h0100, 16'h0200, 16'h0300};
    logic [1:0]  cmp_exp[4] = '{2'b11, 2'b00, 2'b11, 2'b10};
    ccu_mode_t   cap_mode[4] = '{CCU_CAP_FALL, CCU_CAP_RISE, CCU_CAP_RISE4, CCU_CAP_RISE16};
    int          cap_n[4] = '{1, 1, 4, 16};
    ccu_link_if link ();
    // The pin carries the partner's drive when enabled, else the outside level.
    assign pin_level = pin_drive_oe ? pin_drive : pin_ext;
    ccu_unit ccu_unit_i (.REF_CLK(clk), .SRST(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
        .PORT_DATA(port_data), .LINK(link));
    ccu_partner #(.TICK_DIV(16'h0001)) ccu_partner_i (.REF_CLK(clk), .SRST(srst),
        .TIMER_ON(timer_on), .CONV_ON(conv_on), .PIN_LEVEL(pin_level), .CONV_BUSY(conv_busy),
        .OVERFLOW(overflow), .PIN_DRIVE(pin_drive), .PIN_DRIVE_OE(pin_drive_oe), .LINK(link));
    ccu_link_props ccu_link_props_i (.REF_CLK(clk), .SRST(srst), .timer_count(link.timer_count),
        .timer_tick(link.timer_tick), .timer_clear(link.timer_clear),
        .conv_start(link.conv_start), .pin_oe(link.pin_oe));
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (mon) begin
            nconv += int'(link.conv_start);
            nbusy += int'(conv_busy);
            novf += int'(overflow);
            if (link.timer_count > maxc) maxc = link.timer_count;
        end
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------------------------------
    task automatic end_of_test();
        if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wait_flag();
        int k;
        k = 0;
        do begin
            rd(8'h0C);
            k++;
        end while (q[0] !== 1'b1 && k < 500);
    endtask : wait_flag
    task automatic pin_to(input logic v);
        pin_ext <= v;
        repeat (8) @(posedge clk);
    endtask : pin_to
    task automatic rst();
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask : rst
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        rst();
        rd(8'h00); check("control reset", 32'h0, q);
        rd(8'h14); check("direction reset", 32'h1, q);
        rd(8'h20); check("unmapped read", 32'h0, q);
        timer_on <= 1'b1;
        wr(8'h14, 32'h0); check("pin owner", 32'h1, 32'(link.pin_oe));
        for (int i = 0; i < 4; i++) begin
            wr(8'h04, 32'(cmp_at[i][7:0]));
            wr(8'h08, 32'(cmp_at[i][15:8]));
            wr(8'h00, 32'(cmp_mode[i]));
            wr(8'h0C, 32'h1);
            wait_flag(); check("compare flag", 32'h1, 32'(q[0]));
            check("compare latch", 32'(cmp_exp[i][1]), 32'(q[3]));
            check("compare pin", 32'(cmp_exp[i][0]), 32'(link.pin_out));
        end
        port_data <= 1'b1;
        wr(8'h00, 32'h0);
        rd(8'h0C); check("latch off", 32'h0, 32'(q[3]));
        check("pin off", 32'h1, 32'(link.pin_out));
        rst();
        conv_on <= 1'b1;
        wr(8'h04, 32'h40);
        wr(8'h00, 32'(CCU_CMP_TRIG));
        mon <= 1'b1;
        repeat (400) @(posedge clk);
        mon <= 1'b0;
        check("overflow pulses", 32'h0, novf);
        check("busy per start", nconv, nbusy);
        check("start count", 32'h1, 32'(nconv >= 5 && nconv <= 7));
        check("period bound", 32'h0000_0040, 32'(maxc));
        check("trigger pin", 32'h1, 32'(link.pin_out));
        rst();
        timer_on <= 1'b0;
        repeat (4) @(posedge clk);
        tcap = link.timer_count;
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'h0);
            wr(8'h00, 32'(cap_mode[i]));
            wr(8'h0C, 32'h1);
            repeat (cap_n[i] - 1) begin
                pin_to(1'b1);
                pin_to(1'b0);
            end
            rd(8'h0C); check("capture early", 32'h0, 32'(q[0]));
            pin_to(1'b1);
            rd(8'h0C); check("capture rise", 32'(i != 0), 32'(q[0]));
            pin_to(1'b0);
            rd(8'h0C); check("capture flag", 32'h1, 32'(q[0]));
            rd(8'h04);
            lo = q[7:0];
            rd(8'h08); check("capture value", 32'(tcap), {16'h0, q[7:0], lo});
        end
        repeat (3) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
        wr(8'h00, 32'h0);
        wr(8'h00, 32'(CCU_CAP_RISE4));
        wr(8'h0C, 32'h1);
        repeat (3) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
        rd(8'h0C); check("prescaler cleared", 32'h0, 32'(q[0]));
        end_of_test();
    end
endmodule : ccu_unit_tb
`default_nettype wire

// >>> verilog/ccu_defines.svh
// Offsets, field positions, reset values and timing counts of the capture/compare unit.
`ifndef CCU_DEFINES_SVH
`define CCU_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define CCU_OFS_CONTROL    8'h00
`define CCU_OFS_MATCH_LOW  8'h04
`define CCU_OFS_MATCH_HIGH 8'h08
`define CCU_OFS_STATUS     8'h0C
`define CCU_OFS_TIMER      8'h10
`define CCU_OFS_PIN_CTRL   8'h14

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CCU_MODE_LSB       0
`define CCU_MODE_MSB       3
`define CCU_DUTY_LSB       4
`define CCU_DUTY_MSB       5
`define CCU_CFG_BIT        7
`define CCU_CONTROL_MASK   8'hBF
`define CCU_CONTROL_RESET  8'h00
`define CCU_MATCH_RESET    8'h00
`define CCU_STAT_FLAG      0
`define CCU_STAT_OVF       1
`define CCU_STAT_ENABLE    2
`define CCU_STAT_PIN       3
`define CCU_PIN_DIR        0
`define CCU_PIN_TIMER_ON   1
`define CCU_PIN_CONV_ON    2

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define CCU_PRESCALE_4     4'h3
`define CCU_PRESCALE_16    4'hF
`define CCU_TICK_DIV       16'h0004

`endif

// >>> verilog/ccu_link_if.sv
// Link between the capture/compare unit and its timer, converter and pin.
`timescale 1ns/1ps
`default_nettype none
interface ccu_link_if;
    logic [15:0] timer_count;
    logic        timer_tick;
    logic        timer_clear;
    logic        conv_start;
    logic        pin_in;
    logic        pin_out;
    logic        pin_oe;

    modport unit (
        input  timer_count, timer_tick, pin_in,
        output timer_clear, conv_start, pin_out, pin_oe
    );
    modport partner (
        output timer_count, timer_tick, pin_in,
        input  timer_clear, conv_start, pin_out, pin_oe
    );
endinterface : ccu_link_if
`default_nettype wire

// >>> verilog/ccu_partner.sv
// Partner end: sixteen-bit timer, conversion start and unsampled pin pass-through.
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"
module ccu_partner import ccu_pkg::*; #(
    parameter logic [15:0] TICK_DIV = `CCU_TICK_DIV
) (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        SRST,
    // User side
    input  wire logic        TIMER_ON,
    input  wire logic        CONV_ON,
    input  wire logic        PIN_LEVEL,
    output var  logic        CONV_BUSY,
    output var  logic        OVERFLOW,
    output var  logic        PIN_DRIVE,
    output var  logic        PIN_DRIVE_OE,
    // Link to the unit
    ccu_link_if.partner      LINK
);
    // A zero divider would let the timer tick only once every 65536 cycles.
    if (TICK_DIV == 16'h0000) begin : g_bad_div
        $error("TICK_DIV must be nonzero");
    end

    // ----------------------------------------------------------------
    // Synchronous timer, ticking once per divided period
    // ----------------------------------------------------------------
    logic [15:0] div_ff;
    logic [15:0] count_ff;
    logic        conv_ff;
    logic        ovf_ff;
    wire  logic  tick_now = TIMER_ON && (div_ff == TICK_DIV - 16'h0001); // see R1

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            div_ff    <= 16'h0000;
            count_ff  <= 16'h0000;
            conv_ff   <= 1'b0;
            ovf_ff    <= 1'b0;
        end else begin
            div_ff  <= tick_now ? 16'h0000 : (TIMER_ON ? div_ff + 16'h0001 : div_ff);
            ovf_ff  <= 1'b0;
            if (tick_now && LINK.timer_clear) begin
                count_ff <= 16'h0000;
            end else if (tick_now) begin
                count_ff <= count_ff + 16'h0001;
                ovf_ff   <= (count_ff == 16'hFFFF);
            end
            conv_ff <= LINK.conv_start && CONV_ON;
        end
    end

    assign LINK.timer_count = count_ff;
    assign LINK.timer_tick  = tick_now;
    assign LINK.pin_in      = PIN_LEVEL;
    assign CONV_BUSY        = conv_ff;
    assign OVERFLOW         = ovf_ff;
    assign PIN_DRIVE        = LINK.pin_out;
    assign PIN_DRIVE_OE     = LINK.pin_oe;
endmodule : ccu_partner
`default_nettype wire

// >>> verilog/ccu_pkg.sv
// Types shared by both ends of the capture/compare unit.
package ccu_pkg;
    typedef enum logic [3:0] {
        CCU_OFF        = 4'h0,
        CCU_RSVD1      = 4'h1,
        CCU_CMP_TOGGLE = 4'h2,
        CCU_RSVD3      = 4'h3,
        CCU_CAP_FALL   = 4'h4,
        CCU_CAP_RISE   = 4'h5,
        CCU_CAP_RISE4  = 4'h6,
        CCU_CAP_RISE16 = 4'h7,
        CCU_CMP_SET    = 4'h8,
        CCU_CMP_CLEAR  = 4'h9,
        CCU_CMP_FLAG   = 4'hA,
        CCU_CMP_TRIG   = 4'hB,
        CCU_PWM_0      = 4'hC,
        CCU_PWM_1      = 4'hD,
        CCU_PWM_2      = 4'hE,
        CCU_PWM_3      = 4'hF
    } ccu_mode_t;
endpackage : ccu_pkg

// >>> verilog/ccu_unit.sv
// Capture/compare unit with a classic Wishbone register slave.
//
// Overview of operation
// R1 - Timer must run synchronised with this unit.
// R2 - Prescaler cleared when off or not capturing.
// R3 - Every reset clears the prescaler counter.
// R4 - Clear control before changing capture prescale.
// R5 - Software masks and clears flag on mode change.
// R6 - Compare pair continuously matched against timer.
// R7 - Match performs mode-selected pin or trigger action.
// R8 - Every compare match sets the event flag.
// R9 - Zero control forces compare latch low.
// R10 - Software drives pin as output for compare.
// R11 - Mode 1010 only flags, pin untouched.
// R12 - Mode 1011 resets timer, starts conversion.
// R13 - Trigger immediate; timer clears next tick.
// R14 - Trigger reset never sets overflow flag.
// R15 - Lost match cancels pending timer reset.
// R16 - PWM pin ownership; direction bit enables driver.
// R17 - Zero control releases pin to port.
// R18 - Modes 0100-0111 select capture edges.
// R19 - Modes 0010, 1000, 1001 toggle, set, clear.
// R20 - Capture copies timer, sets flag, overwrites.
// R21 - Mode 0000 turns unit off, resets state.
// R22 - Conversion start is one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.svh"
module ccu_unit import ccu_pkg::*; (
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        SRST,
    // Wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output var  logic [31:0] DAT_O,
    output var  logic        ACK_O,
    // Port data latch for when the unit does not own the pin
    input  wire logic        PORT_DATA,
    // Link to timer, converter and pin
    ccu_link_if.unit         LINK
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]  unit_control_ff;
    logic [7:0]  match_value_low_ff;
    logic [7:0]  match_value_high_ff;
    logic        unit_event_flag_ff;
    logic        timer_overflow_flag_ff;
    logic        unit_event_enable_ff;
    logic        pin_direction_bit_ff;
    logic        cmp_latch_ff;
    logic [3:0]  prescale_ff;
    logic [2:0]  pin_sync_ff;
    logic        pin_lvl_ff;
    logic        match_prev_ff;
    logic        conv_pulse_ff;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire ccu_mode_t   mode        = ccu_mode_t'(unit_control_ff[`CCU_MODE_MSB:`CCU_MODE_LSB]);
    wire logic [15:0] match_pair  = {match_value_high_ff, match_value_low_ff};
    wire logic        is_capture  = (unit_control_ff[3:2] == 2'b01);
    wire logic        is_compare  = (mode == CCU_CMP_TOGGLE) || (unit_control_ff[3:2] == 2'b10);
    wire logic        is_pwm      = (unit_control_ff[3:2] == 2'b11);
    wire logic        owns_pin    = (mode == CCU_CMP_TOGGLE) || (mode == CCU_CMP_SET)
                                    || (mode == CCU_CMP_CLEAR) || is_pwm;
    wire logic        match       = is_compare && (LINK.timer_count == match_pair); // see R6
    wire logic        match_rise  = match && !match_prev_ff;
    // A pin level counts only once the last two sync stages agree.
    wire logic        pin_agree   = (pin_sync_ff[1] == pin_sync_ff[2]);
    wire logic        pin_rise    = pin_agree && pin_sync_ff[2] && !pin_lvl_ff;
    wire logic        pin_fall    = pin_agree && !pin_sync_ff[2] && pin_lvl_ff;
    wire logic [3:0]  prescale_top = (mode == CCU_CAP_RISE4) ? `CCU_PRESCALE_4
                                    : (mode == CCU_CAP_RISE16) ? `CCU_PRESCALE_16 : 4'h0;
    wire logic        prescale_wrap = (prescale_ff == prescale_top);
    wire logic        capture_evt = is_capture && (((mode == CCU_CAP_FALL) && pin_fall)
                                    || ((mode != CCU_CAP_FALL) && pin_rise && prescale_wrap)); // see R18
    wire logic        wb_req      = CYC_I && STB_I && !ACK_O;
    wire logic        wb_wr       = wb_req && WE_I && SEL_I[0];
    wire logic        wr_ctrl     = wb_wr && (ADR_I == `CCU_OFS_CONTROL);
    wire logic        wr_low      = wb_wr && (ADR_I == `CCU_OFS_MATCH_LOW);
    wire logic        wr_high     = wb_wr && (ADR_I == `CCU_OFS_MATCH_HIGH);
    wire logic        wr_stat     = wb_wr && (ADR_I == `CCU_OFS_STATUS);
    wire logic        wr_pin      = wb_wr && (ADR_I == `CCU_OFS_PIN_CTRL);
    wire logic        ctrl_zero   = wr_ctrl && (DAT_I[7:0] == 8'h00);
    wire logic [15:0] capture_val = LINK.timer_count;
    wire logic        hit_evt     = match_rise || capture_evt;
    wire logic        unit_off    = (mode == CCU_OFF); // see R21
    // The clear request stands only while the trigger match does.
    wire logic        trig_hold   = match && (mode == CCU_CMP_TRIG); // see R13, R15
    logic [31:0]      rd_data;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (ADR_I == `CCU_OFS_CONTROL) begin
            rd_data[7:0] = unit_control_ff;
        end else if (ADR_I == `CCU_OFS_MATCH_LOW) begin
            rd_data[7:0] = match_value_low_ff;
        end else if (ADR_I == `CCU_OFS_MATCH_HIGH) begin
            rd_data[7:0] = match_value_high_ff;
        end else if (ADR_I == `CCU_OFS_STATUS) begin
            rd_data[`CCU_STAT_FLAG]   = unit_event_flag_ff;
            rd_data[`CCU_STAT_OVF]    = timer_overflow_flag_ff;
            rd_data[`CCU_STAT_ENABLE] = unit_event_enable_ff;
            rd_data[`CCU_STAT_PIN]    = cmp_latch_ff;
        end else if (ADR_I == `CCU_OFS_TIMER) begin
            rd_data[15:0] = LINK.timer_count;
        end else if (ADR_I == `CCU_OFS_PIN_CTRL) begin
            rd_data[`CCU_PIN_DIR] = pin_direction_bit_ff;
        end
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ACK_O                <= 1'b0;
            DAT_O                <= 32'h0000_0000;
            unit_control_ff      <= `CCU_CONTROL_RESET;
            unit_event_enable_ff <= 1'b0;
            pin_direction_bit_ff <= 1'b1;
        end else begin
            ACK_O <= wb_req;
            DAT_O <= wb_req ? rd_data : DAT_O;
            if (wr_ctrl) begin
                unit_control_ff <= DAT_I[7:0] & `CCU_CONTROL_MASK; // see R4
            end
            if (wr_stat) begin
                unit_event_enable_ff <= DAT_I[`CCU_STAT_ENABLE]; // see R5
            end
            if (wr_pin) begin
                pin_direction_bit_ff <= DAT_I[`CCU_PIN_DIR]; // see R10
            end
        end
    end

    // ----------------------------------------------------------------
    // Match register and capture
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            match_value_low_ff  <= `CCU_MATCH_RESET;
            match_value_high_ff <= `CCU_MATCH_RESET;
        end else if (capture_evt) begin
            match_value_low_ff  <= capture_val[7:0]; // see R20
            match_value_high_ff <= capture_val[15:8];
        end else begin
            if (wr_low) begin
                match_value_low_ff <= DAT_I[7:0];
            end
            if (wr_high && !is_pwm) begin
                match_value_high_ff <= DAT_I[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Flags, prescaler, compare latch and trigger
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            unit_event_flag_ff     <= 1'b0;
            timer_overflow_flag_ff <= 1'b0;
            prescale_ff            <= 4'h0; // see R3
            pin_sync_ff            <= 3'b000;
            cmp_latch_ff           <= 1'b0;
            pin_lvl_ff             <= 1'b0;
            match_prev_ff          <= 1'b0;
            conv_pulse_ff          <= 1'b0;
        end else begin
            pin_sync_ff   <= {pin_sync_ff[1:0], LINK.pin_in};
            pin_lvl_ff    <= pin_agree ? pin_sync_ff[2] : pin_lvl_ff;
            match_prev_ff <= match;
            if (hit_evt) begin
                unit_event_flag_ff <= 1'b1; // see R8
            end else if (wr_stat && DAT_I[`CCU_STAT_FLAG]) begin
                unit_event_flag_ff <= 1'b0;
            end
            if (wr_stat && DAT_I[`CCU_STAT_OVF]) begin
                timer_overflow_flag_ff <= 1'b0; // see R14
            end
            if (!is_capture || unit_off) begin
                prescale_ff <= 4'h0; // see R2
            end else if (pin_rise && mode != CCU_CAP_FALL) begin
                prescale_ff <= prescale_wrap ? 4'h0 : prescale_ff + 4'h1;
            end
            if (ctrl_zero) begin
                cmp_latch_ff <= 1'b0; // see R9
            end else if (match_rise) begin
                case (mode) // see R7
                    CCU_CMP_TOGGLE: cmp_latch_ff <= !cmp_latch_ff; // see R19
                    CCU_CMP_SET:    cmp_latch_ff <= 1'b1;
                    CCU_CMP_CLEAR:  cmp_latch_ff <= 1'b0;
                    default:        cmp_latch_ff <= cmp_latch_ff; // see R11
                endcase
            end
            conv_pulse_ff <= match_rise && (mode == CCU_CMP_TRIG); // see R22
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign LINK.timer_clear = trig_hold; // see R12
    assign LINK.conv_start  = conv_pulse_ff;
    assign LINK.pin_out     = owns_pin ? cmp_latch_ff : PORT_DATA; // see R17
    assign LINK.pin_oe      = !pin_direction_bit_ff; // see R16
    wire logic unused_ok = ^{unit_control_ff[`CCU_CFG_BIT], unit_control_ff[5:4],
                             DAT_I[31:8], SEL_I[3:1], unit_event_enable_ff, LINK.timer_tick};
endmodule : ccu_unit
`default_nettype wire
